// ### src/abm_map.svh
// timing constants and pin levels for the byte memory port controller
`ifndef ABM_MAP_SVH
`define ABM_MAP_SVH
`define ABM_CLK_PERIOD_NS     8
`define ABM_STARTUP_NS        2000000
`define ABM_CYCLE_TIME_NS     35
`define ABM_WRITE_PULSE_NS    15
`define ABM_ADDR_TO_END_G_NS  18
`define ABM_DATA_SETUP_NS     10
`define ABM_READ_ACCESS_NS    35
`define ABM_GATE_ACCESS_NS    15
`define ABM_GATE_FLOAT_NS     10
`define ABM_HIGH_MIN_NS       2
// least times round up to whole cycles
`define ABM_CYC_UP(ns)        (((ns) + `ABM_CLK_PERIOD_NS - 1) / `ABM_CLK_PERIOD_NS)
`define ABM_PIN_HIGH          1'b1
`define ABM_PIN_LOW           1'b0
`endif

// ### src/abm_pkg.sv
// types for the byte memory port controller
package abm_pkg;
   typedef enum logic [2:0] {
      ABM_ST_STARTUP = 3'b000,
      ABM_ST_IDLE    = 3'b001,
      ABM_ST_RD_ACC  = 3'b010,
      ABM_ST_WR_PLS  = 3'b011,
      ABM_ST_RECOVER = 3'b100
   } abm_state_e;
endpackage : abm_pkg

// ### src/abm_host_ctrl.sv
// host controller driving an asynchronous byte-wide memory over its pins
`include "abm_map.svh"
`timescale 1ns/1ns
`default_nettype none
module abm_host_ctrl #(
   parameter int unsigned ADDR_W         = 19,
   parameter int unsigned DATA_W         = 8,
   parameter int unsigned STARTUP_CYCLES = `ABM_CYC_UP(`ABM_STARTUP_NS)
) (
   input  wire logic                   sys_clk,
   input  wire logic                   resetn,
   input  wire logic                   supply_good,
   input  wire logic                   req_valid,
   input  wire logic                   req_write,
   input  wire logic [ADDR_W-1:0]      req_addr,
   input  wire logic [DATA_W-1:0]      req_wdata,
   output var  logic                   req_ready,
   output var  logic                   rsp_valid,
   output var  logic [DATA_W-1:0]      rsp_rdata,
   output var  logic                   mem_ready,
   output var  logic [ADDR_W-1:0]      mem_addr,
   output var  logic                   mem_sel_n,
   output var  logic                   mem_wr_n,
   output var  logic                   mem_oe_n,
   input  wire logic [DATA_W-1:0]      mem_dq_i,
   output var  logic [DATA_W-1:0]      mem_dq_o,
   output var  logic                   mem_dq_oe
);
   import abm_pkg::*;

   localparam int unsigned RD_CYC  = `ABM_CYC_UP(`ABM_READ_ACCESS_NS) + 1;
   // write low long enough for pulse width, address-to-end and data setup
   localparam int unsigned WR_CYC  = `ABM_CYC_UP(`ABM_ADDR_TO_END_G_NS + 2) + 1;
   // recovery keeps strobes high and address stable, makes the 35 ns cycle and lets data float
   localparam int unsigned REC_CYC = `ABM_CYC_UP(`ABM_GATE_FLOAT_NS) + 1;
   localparam int unsigned CNT_W   = $clog2(STARTUP_CYCLES + 1) + 1;

   function automatic logic [CNT_W-1:0] cyc(input int unsigned n);
      cyc = CNT_W'(n - 1);
   endfunction : cyc

   // supply_good is asynchronous: three stages, change counted when 2nd and 3rd agree
   logic [2:0]        sup_sync_reg;
   logic              sup_ok_reg;
   logic              sup_ok_next;

   abm_state_e        state_reg,   state_next;
   logic [CNT_W-1:0]  cnt_reg,     cnt_next;
   logic [ADDR_W-1:0] addr_reg,    addr_next;
   logic [DATA_W-1:0] wdata_reg,   wdata_next;
   logic              sel_n_reg,   sel_n_next;
   logic              wr_n_reg,    wr_n_next;
   logic              oe_n_reg,    oe_n_next;
   logic              dq_oe_reg,   dq_oe_next;
   logic              ready_reg,   ready_next;
   logic              rsp_v_reg,   rsp_v_next;
   logic [DATA_W-1:0] rdata_reg,   rdata_next;
   logic              mready_reg,  mready_next;

   always_comb begin
      sup_ok_next = sup_ok_reg;
      if (sup_sync_reg[1] == sup_sync_reg[2]) begin
         sup_ok_next = sup_sync_reg[2];
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         sup_sync_reg <= 3'h0;
         sup_ok_reg   <= 1'b0;
      end else begin
         sup_sync_reg <= {sup_sync_reg[1:0], supply_good};
         sup_ok_reg   <= sup_ok_next;
      end
   end

   always_comb begin
      state_next  = state_reg;
      cnt_next    = cnt_reg;
      addr_next   = addr_reg;
      wdata_next  = wdata_reg;
      sel_n_next  = sel_n_reg;
      wr_n_next   = wr_n_reg;
      oe_n_next   = oe_n_reg;
      dq_oe_next  = dq_oe_reg;
      ready_next  = 1'b0;
      rsp_v_next  = 1'b0;
      rdata_next  = rdata_reg;
      mready_next = mready_reg;
      case (state_reg)
         ABM_ST_STARTUP: begin
            sel_n_next  = `ABM_PIN_HIGH;
            wr_n_next   = `ABM_PIN_HIGH;
            oe_n_next   = `ABM_PIN_HIGH;
            dq_oe_next  = 1'b0;
            mready_next = 1'b0;
            if (!sup_ok_reg) begin
               cnt_next = cyc(STARTUP_CYCLES);
            end else if (cnt_reg == '0) begin
               state_next  = ABM_ST_IDLE;
               mready_next = 1'b1;
               ready_next  = 1'b1;
            end else begin
               cnt_next = cnt_reg - 1'b1;
            end
         end
         ABM_ST_IDLE: begin
            ready_next = 1'b1;
            if (req_valid && ready_reg) begin
               ready_next = 1'b0;
               addr_next  = req_addr;
               sel_n_next = `ABM_PIN_LOW;
               if (req_write) begin
                  // output gate stays high through the write, outputs float
                  wdata_next = req_wdata;
                  dq_oe_next = 1'b1;
                  wr_n_next  = `ABM_PIN_LOW;
                  cnt_next   = cyc(WR_CYC);
                  state_next = ABM_ST_WR_PLS;
               end else begin
                  wr_n_next  = `ABM_PIN_HIGH;
                  oe_n_next  = `ABM_PIN_LOW;
                  cnt_next   = cyc(RD_CYC);
                  state_next = ABM_ST_RD_ACC;
               end
            end
         end
         ABM_ST_RD_ACC: begin
            if (cnt_reg == '0) begin
               rdata_next = mem_dq_i;
               rsp_v_next = 1'b1;
               sel_n_next = `ABM_PIN_HIGH;
               oe_n_next  = `ABM_PIN_HIGH;
               cnt_next   = cyc(REC_CYC);
               state_next = ABM_ST_RECOVER;
            end else begin
               cnt_next = cnt_reg - 1'b1;
            end
         end
         ABM_ST_WR_PLS: begin
            if (cnt_reg == '0) begin
               // both strobes rise together; data and address held past the edge
               wr_n_next  = `ABM_PIN_HIGH;
               sel_n_next = `ABM_PIN_HIGH;
               rsp_v_next = 1'b1;
               cnt_next   = cyc(REC_CYC);
               state_next = ABM_ST_RECOVER;
            end else begin
               cnt_next = cnt_reg - 1'b1;
            end
         end
         ABM_ST_RECOVER: begin
            dq_oe_next = 1'b0;
            if (cnt_reg == '0) begin
               state_next = ABM_ST_IDLE;
               ready_next = 1'b1;
            end else begin
               cnt_next = cnt_reg - 1'b1;
            end
         end
         default: begin
            state_next = ABM_ST_STARTUP;
         end
      endcase
      // brownout: drop back to a full startup wait, strobes forced high
      if (!sup_ok_reg && state_reg != ABM_ST_STARTUP) begin
         state_next  = ABM_ST_STARTUP;
         cnt_next    = cyc(STARTUP_CYCLES);
         sel_n_next  = `ABM_PIN_HIGH;
         wr_n_next   = `ABM_PIN_HIGH;
         oe_n_next   = `ABM_PIN_HIGH;
         dq_oe_next  = 1'b0;
         ready_next  = 1'b0;
         rsp_v_next  = 1'b0;
         mready_next = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state_reg  <= ABM_ST_STARTUP;
         cnt_reg    <= '0;
         addr_reg   <= '0;
         wdata_reg  <= '0;
         sel_n_reg  <= `ABM_PIN_HIGH;
         wr_n_reg   <= `ABM_PIN_HIGH;
         oe_n_reg   <= `ABM_PIN_HIGH;
         dq_oe_reg  <= 1'b0;
         ready_reg  <= 1'b0;
         rsp_v_reg  <= 1'b0;
         rdata_reg  <= '0;
         mready_reg <= 1'b0;
      end else begin
         state_reg  <= state_next;
         cnt_reg    <= cnt_next;
         addr_reg   <= addr_next;
         wdata_reg  <= wdata_next;
         sel_n_reg  <= sel_n_next;
         wr_n_reg   <= wr_n_next;
         oe_n_reg   <= oe_n_next;
         dq_oe_reg  <= dq_oe_next;
         ready_reg  <= ready_next;
         rsp_v_reg  <= rsp_v_next;
         rdata_reg  <= rdata_next;
         mready_reg <= mready_next;
      end
   end

   assign req_ready = ready_reg;
   assign rsp_valid = rsp_v_reg;
   assign rsp_rdata = rdata_reg;
   assign mem_ready = mready_reg;
   assign mem_addr  = addr_reg;
   assign mem_sel_n = sel_n_reg;
   assign mem_wr_n  = wr_n_reg;
   assign mem_oe_n  = oe_n_reg;
   assign mem_dq_o  = wdata_reg;
   assign mem_dq_oe = dq_oe_reg;
endmodule : abm_host_ctrl
`default_nettype wire

// ### dv/abm_host_ctrl_assertions.sv
// pin timing checker for the byte memory port controller
`timescale 1ns/1ns
`default_nettype none
module abm_host_ctrl_chk #(
   parameter int unsigned ADDR_W         = 19,
   parameter int unsigned DATA_W         = 8,
   parameter int unsigned STARTUP_CYCLES = 20
) (
   input wire logic              sys_clk,
   input wire logic              resetn,
   input wire logic              supply_good,
   input wire logic              mem_ready,
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire logic              mem_sel_n,
   input wire logic              mem_wr_n,
   input wire logic              mem_oe_n,
   input wire logic [DATA_W-1:0] mem_dq_o,
   input wire logic              mem_dq_oe
);
   // counts from raw supply good, so it runs ahead of the design's synchronised count
   int unsigned up_cnt;
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) up_cnt <= 0;
      else if (!supply_good) up_cnt <= 0;
      else if (!mem_ready) up_cnt <= up_cnt + 1;
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   startup_hold_a: assert property (!mem_ready |-> mem_sel_n && mem_wr_n)
      else $error("strobe low before ready");
   startup_wait_a: assert property ($rose(mem_ready) |-> up_cnt >= STARTUP_CYCLES)
      else $error("ready before startup wait");
   brownout_drop_a: assert property ($fell(supply_good) |-> ##[1:6] !mem_ready)
      else $error("ready kept in brownout");
   read_strobe_a: assert property (!mem_oe_n |-> mem_wr_n && !mem_dq_oe)
      else $error("write strobe or drive in read");
   sel_addr_a: assert property (!mem_sel_n && !$fell(mem_sel_n) |-> $stable(mem_addr))
      else $error("address moved while selected");
   write_pulse_a: assert property ($fell(mem_wr_n) |-> (!mem_wr_n && !mem_sel_n && mem_dq_oe)[*3])
      else $error("write pulse short");
   data_setup_a: assert property ($rose(mem_wr_n) |-> $past(mem_dq_oe, 2) && $past(mem_dq_o) == $past(mem_dq_o, 2))
      else $error("write data setup short");
   high_time_a: assert property ($rose(mem_wr_n) || $rose(mem_sel_n) |=> mem_wr_n && mem_sel_n)
      else $error("strobe high too short");
   fall_space_a: assert property ($fell(mem_sel_n) |=> (!$fell(mem_sel_n))[*4])
      else $error("select falls too close");
   addr_space_a: assert property ($changed(mem_addr) |=> $stable(mem_addr)[*4])
      else $error("address changes too close");
   read_wait_a: assert property ($fell(mem_oe_n) |-> (!mem_oe_n)[*5])
      else $error("read gate too short");
endmodule : abm_host_ctrl_chk
bind abm_host_ctrl abm_host_ctrl_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .STARTUP_CYCLES(STARTUP_CYCLES)) u_chk (
   .sys_clk(sys_clk), .resetn(resetn), .supply_good(supply_good), .mem_ready(mem_ready), .mem_addr(mem_addr),
   .mem_sel_n(mem_sel_n), .mem_wr_n(mem_wr_n), .mem_oe_n(mem_oe_n), .mem_dq_o(mem_dq_o), .mem_dq_oe(mem_dq_oe));
`default_nettype wire

// ### dv/abm_mem_model.sv
// behavioural model of the asynchronous byte memory
`timescale 1ns/1ns
`default_nettype none
module abm_mem_model (
   input  wire logic        supply_ok,
   input  wire logic [18:0] addr,
   input  wire logic        sel_n,
   input  wire logic        wr_n,
   input  wire logic        oe_n,
   input  wire logic [7:0]  dq_in,
   output var  logic [7:0]  dq_out
);
   logic [7:0] mem [0:524287];
   initial dq_out = 8'h5a;
   always @* if (supply_ok && !sel_n && !wr_n) mem[addr] = dq_in;
   // released bus flips so a late sample never looks like valid data
   always @(sel_n or wr_n or oe_n or addr) begin
      if (!sel_n && wr_n && !oe_n) dq_out <= #35 mem[addr];
      else dq_out <= #3 ~dq_out;
   end
endmodule : abm_mem_model
`default_nettype wire

// ### dv/abm_host_ctrl_test.sv
// self-checking bench for the byte memory port controller
`timescale 1ns/1ns
`default_nettype none
module abm_host_ctrl_test;
   localparam int SU = 20;
   typedef struct packed {logic wr; logic [18:0] a; logic [7:0] d;} abm_row_s;
   abm_row_s rows [8] = '{'{1, 19'h00000, 8'h3c}, '{1, 19'h7ffff, 8'hc3}, '{1, 19'h00001, 8'ha5},
      '{0, 19'h00000, 8'h3c}, '{0, 19'h7ffff, 8'hc3}, '{0, 19'h00001, 8'ha5}, '{1, 19'h00001, 8'h5a},
      '{0, 19'h00001, 8'h5a}};
   logic sys_clk = 1'b0, resetn = 1'b0, supply_good = 1'b1, req_valid = 1'b0, req_write = 1'b0;
   logic [18:0] req_addr = '0, mem_addr;
   logic [7:0] req_wdata = '0, rsp_rdata, mem_dq_o, dev_dq, q;
   logic req_ready, rsp_valid, mem_ready, mem_sel_n, mem_wr_n, mem_oe_n, mem_dq_oe;
   wire logic [7:0] mem_dq_i = mem_dq_oe ? mem_dq_o : dev_dq;
   int err_total = 0, checks = 0, n;
   always #4 sys_clk = ~sys_clk;
   abm_host_ctrl #(.STARTUP_CYCLES(SU)) u_dut (.sys_clk(sys_clk), .resetn(resetn), .supply_good(supply_good),
      .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_ready(mem_ready),
      .mem_addr(mem_addr), .mem_sel_n(mem_sel_n), .mem_wr_n(mem_wr_n), .mem_oe_n(mem_oe_n),
      .mem_dq_i(mem_dq_i), .mem_dq_o(mem_dq_o), .mem_dq_oe(mem_dq_oe));
   abm_mem_model u_mem (.supply_ok(supply_good), .addr(mem_addr), .sel_n(mem_sel_n), .wr_n(mem_wr_n),
      .oe_n(mem_oe_n), .dq_in(mem_dq_i), .dq_out(dev_dq));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         err_total++;
      end
   endtask : chk
   // ready and valid are looked at on the falling edge, where they are settled
   task automatic req(input abm_row_s r, output logic [7:0] rd);
      n = 0;
      @(posedge sys_clk);
      req_valid <= 1'b1;
      {req_write, req_addr, req_wdata} <= r;
      do @(negedge sys_clk); while (req_ready !== 1'b1 && ++n < 400);
      // taking edge: valid drops here so the request is never taken twice
      @(posedge sys_clk);
      req_valid <= 1'b0;
      do @(negedge sys_clk); while (rsp_valid !== 1'b1 && ++n < 400);
      if (n >= 400) err_total++;
      rd = rsp_rdata;
   endtask : req
   task automatic wait_up(input int lo);
      n = 0;
      while (mem_ready !== 1'b1 && n < 1000) begin
         @(negedge sys_clk);
         n++;
      end
      chk(8'(n >= lo && n <= lo + 8), 8'h01);
   endtask : wait_up
   task automatic stop_test;
      $display("checks=%0d err_total=%0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : stop_test
   // whole run needs under two hundred cycles; this leaves a wide margin
   initial begin
      #50000;
      err_total++;
      stop_test;
   end
   initial begin
      repeat (16) @(posedge sys_clk);
      chk({4'h0, mem_sel_n, mem_wr_n, mem_oe_n, mem_ready}, 8'h0e);
      resetn <= 1'b1;
      wait_up(SU);
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         req(rows[i], q);
         if (!rows[i].wr) chk(q, rows[i].d);
      end
      $display("test rows done");
      @(posedge sys_clk);
      supply_good <= 1'b0;
      repeat (10) @(posedge sys_clk);
      chk({4'h0, mem_sel_n, mem_wr_n, mem_oe_n, mem_ready}, 8'h0e);
      supply_good <= 1'b1;
      wait_up(SU);
      req(rows[3], q);
      chk(q, rows[3].d);
      $display("test brownout done");
      stop_test;
   end
endmodule : abm_host_ctrl_test
`default_nettype wire
